/* File: trc_map.svh */
// Register offsets, field positions, reset values and timing counts of the tone and ringing block.
// Contract
// - Indirect pending bit 0 reads 1 while a transfer is outstanding; read-only.
// - Tone one status bit 7 reads 1 while its output is active.
// - Bit 6 selects reload; cleared, tone one stops after the inactive timer.
// - With reload set, tone one keeps cycling instead of halting.
// - Bit 5 ends tone one at timer expiry or next zero crossing.
// - Bit 4 enables the tone one active-period timer.
// - Bit 3 enables the tone one inactive-period timer.
// - Bit 2 turns tone oscillator one on or off.
// - Bits 1:0 route tone one: none, transmit, receive, both.
// - Tone two status bit 7 shows activity; bit 6 reads zero.
// - Tone two bit 5 chooses zero-crossing or immediate end.
// - Tone two bit 4 enables its active-period timer.
// - Tone two bit 3 enables its inactive-period timer.
// - Tone two bit 2 turns tone oscillator two on or off.
// - Tone two bits 1:0 route it like tone one.
// - Ringing status bit 7 shows activity; bit 6 reads zero.
// - Ringing drives the line only after meeting dc feed; bit 5 reports it.
// - Ringing bit 4 enables the ringing active-period timer.
// - Ringing bit 3 enables the ringing inactive-period timer.
// - Ringing bit 2 reads back whether the ringing oscillator is enabled.
// - Ringing bit 1 adds a dc offset to the ringing waveform.
// - Ringing bit 0 picks sinusoid or trapezoid waveshape.
// - Indirect transfers happen at the next 16 kHz update; address-only is a read.
// - Cadence timers count in steps of 125 us.
`ifndef TRC_MAP_SVH
`define TRC_MAP_SVH

`define TRC_OFF_IND_DLO   8'h1c
`define TRC_OFF_IND_DHI   8'h1d
`define TRC_OFF_IND_ADDR  8'h1e
`define TRC_OFF_IND_STAT  8'h1f
`define TRC_OFF_TONE1     8'h20
`define TRC_OFF_TONE2     8'h21
`define TRC_OFF_RING      8'h22
`define TRC_OFF_RING_RUN  8'h60

`define TRC_BIT_STATUS    7
`define TRC_BIT_RELOAD    6
`define TRC_BIT_ZC        5
`define TRC_BIT_ON_TMR    4
`define TRC_BIT_OFF_TMR   3
`define TRC_BIT_ENABLE    2
`define TRC_BIT_ROUTE_RX  1
`define TRC_BIT_ROUTE_TX  0
`define TRC_BIT_DC_OFS    1
`define TRC_BIT_SHAPE     0

`define TRC_RESET_BYTE    8'h00

`define TRC_CLK_NS        4
`define TRC_CAD_LSB_NS    125000
`define TRC_IND_RATE_HZ   16000
`define TRC_CAD_CYC       ((`TRC_CAD_LSB_NS + `TRC_CLK_NS - 1) / `TRC_CLK_NS)
`define TRC_IND_CYC       ((1000000000 / `TRC_IND_RATE_HZ + `TRC_CLK_NS - 1) / `TRC_CLK_NS)

`endif

/* File: trc_pkg.sv */
// Types shared by the tone and ringing control block.
package trc_pkg;

	typedef enum logic [2:0] {CAD_IDLE, CAD_ON, CAD_WAIT_ZC, CAD_OFF, CAD_DONE} trc_cad_st_type;

	typedef struct packed {
		trc_cad_st_type st;
		logic [15:0]    cnt;
	} trc_cad_type;

	typedef struct packed {
		logic [15:0] on_cnt;
		logic [15:0] off_cnt;
	} trc_period_type;

	typedef struct packed {
		logic tone_one_tx;
		logic tone_one_rx;
		logic tone_two_tx;
		logic tone_two_rx;
	} trc_route_type;

	typedef struct packed {
		logic ring_active;
		logic ring_line_drive;
		logic ring_dc_offset_en;
		logic ring_waveshape_sel;
	} trc_ring_type;

	typedef struct packed {
		logic        go;
		logic        is_write;
		logic [7:0]  indirect_address;
		logic [15:0] indirect_data;
	} trc_ind_req_type;

	typedef struct packed {
		logic [6:0]  t1_ctrl;
		logic [5:0]  t2_ctrl;
		logic        ring_on_timer_en;
		logic        ring_off_timer_en;
		logic        ring_dc_offset_en;
		logic        ring_waveshape_sel;
		logic        ring_osc_enable;
		logic        ring_on_line_flag;
		logic        indirect_pending;
		logic        data_written;
		logic        go;
		logic        is_write;
		logic [15:0] indirect_data;
		logic [7:0]  indirect_address;
		logic [15:0] cad_div;
		logic [15:0] ind_div;
		logic        cad_tick;
		logic        ind_tick;
		logic [7:0]  rdata;
	} trc_regs_type;

endpackage : trc_pkg

/* File: trc_cadence.sv */
// Active and inactive cadence sequencer for one oscillator.
`timescale 1ns/1ps
`include "trc_map.svh"
module trc_cadence
	import trc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Control
	input  wire logic        tick,
	input  wire logic        enable,
	input  wire logic        on_en,
	input  wire logic        off_en,
	input  wire logic        reload,
	input  wire logic        zc_stop,
	input  wire logic        zero_cross,
	input  wire trc_period_type periods,
	// Status
	output logic             active
);

	trc_cad_type s_q, s_d;
	logic        on_exp, off_exp;

	always_comb begin
		on_exp  = on_en && tick && (16'(s_q.cnt + 16'd1) >= periods.on_cnt);
		off_exp = off_en && tick && (16'(s_q.cnt + 16'd1) >= periods.off_cnt);
		s_d = s_q;
		if (!enable) begin
			s_d.st  = CAD_IDLE;
			s_d.cnt = 16'h0000;
		end else begin
			unique case (s_q.st)
				CAD_IDLE: begin
					s_d.st  = CAD_ON;
					s_d.cnt = 16'h0000;
				end
				CAD_ON: begin
					if (on_exp) begin
						s_d.st  = zc_stop ? CAD_WAIT_ZC : CAD_OFF;
						s_d.cnt = 16'h0000;
					end else if (on_en && tick) begin
						s_d.cnt = 16'(s_q.cnt + 16'd1);
					end
				end
				CAD_WAIT_ZC: begin
					if (zero_cross) begin
						s_d.st = CAD_OFF;
					end
				end
				CAD_OFF: begin
					if (off_exp) begin
						s_d.st  = reload ? CAD_ON : CAD_DONE;
						s_d.cnt = 16'h0000;
					end else if (off_en && tick) begin
						s_d.cnt = 16'(s_q.cnt + 16'd1);
					end
				end
				CAD_DONE: s_d = s_q;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '{st: CAD_IDLE, cnt: 16'h0000};
		end else begin
			s_q <= s_d;
		end
	end

	assign active = (s_q.st == CAD_ON) || (s_q.st == CAD_WAIT_ZC);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_disable_stops: assert property (!enable |=> !active)
		else $error("oscillator active while disabled");
	a_on_holds: assert property (s_q.st == CAD_ON && enable && !on_en |=> active)
		else $error("active period ended with timer disabled");
	a_off_holds: assert property (s_q.st == CAD_OFF && enable && !off_en |=> !active)
		else $error("inactive period ended with timer disabled");
	a_zc_end: assert property ($fell(active) && $past(enable) && $past(zc_stop)
		|-> $past(zero_cross))
		else $error("tone ended without a zero crossing");
	a_reload_run: assert property (s_q.st == CAD_OFF && off_exp && reload && enable
		|=> active)
		else $error("reload did not restart the tone");
	a_no_reload: assert property (s_q.st == CAD_DONE && enable |=> !active)
		else $error("oscillator restarted without reload");

endmodule : trc_cadence

/* File: trc_ctrl.sv */
// Register bank and cadence control for two tone oscillators and the ringing oscillator.
`timescale 1ns/1ps
`include "trc_map.svh"
module trc_ctrl
	import trc_pkg::*;
#(
	parameter int unsigned CAD_CYCLES = `TRC_CAD_CYC,
	parameter int unsigned IND_CYCLES = `TRC_IND_CYC
)(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            nrst,
	// Register port
	input  wire logic [7:0]      reg_addr,
	input  wire logic [7:0]      reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	output logic [7:0]           reg_rdata,
	// Cadence periods in 125 us steps
	input  wire trc_period_type  tone_one_periods,
	input  wire trc_period_type  tone_two_periods,
	input  wire trc_period_type  ring_periods,
	// Waveform events
	input  wire logic            tone_one_zero_cross,
	input  wire logic            tone_two_zero_cross,
	input  wire logic            ring_dc_match,
	// Indirect memory engine
	input  wire logic            ind_rd_valid,
	input  wire logic [15:0]     ind_rd_data,
	output trc_ind_req_type      ind_req,
	// Oscillator outputs
	output trc_route_type        route,
	output trc_ring_type         ring
);

	trc_regs_type r_q, r_d;
	logic         tone_one_active;
	logic         tone_two_active;
	logic         ring_active_status;

	// ****************************************
	// Cadence sequencers
	// ****************************************
	trc_cadence u_tone_one (
		.clk        (clk),
		.nrst       (nrst),
		.tick       (r_q.cad_tick),
		.enable     (r_q.t1_ctrl[`TRC_BIT_ENABLE]),
		.on_en      (r_q.t1_ctrl[`TRC_BIT_ON_TMR]),
		.off_en     (r_q.t1_ctrl[`TRC_BIT_OFF_TMR]),
		.reload     (r_q.t1_ctrl[`TRC_BIT_RELOAD]),
		.zc_stop    (r_q.t1_ctrl[`TRC_BIT_ZC]),
		.zero_cross (tone_one_zero_cross),
		.periods    (tone_one_periods),
		.active     (tone_one_active)
	);

	// Only tone one has a reload choice; tone two keeps cycling.
	trc_cadence u_tone_two (
		.clk        (clk),
		.nrst       (nrst),
		.tick       (r_q.cad_tick),
		.enable     (r_q.t2_ctrl[`TRC_BIT_ENABLE]),
		.on_en      (r_q.t2_ctrl[`TRC_BIT_ON_TMR]),
		.off_en     (r_q.t2_ctrl[`TRC_BIT_OFF_TMR]),
		.reload     (1'b1),
		.zc_stop    (r_q.t2_ctrl[`TRC_BIT_ZC]),
		.zero_cross (tone_two_zero_cross),
		.periods    (tone_two_periods),
		.active     (tone_two_active)
	);

	// The ringing waveform always stops at once; the line hand-over is handled below.
	trc_cadence u_ring (
		.clk        (clk),
		.nrst       (nrst),
		.tick       (r_q.cad_tick),
		.enable     (r_q.ring_osc_enable),
		.on_en      (r_q.ring_on_timer_en),
		.off_en     (r_q.ring_off_timer_en),
		.reload     (1'b1),
		.zc_stop    (1'b0),
		.zero_cross (1'b0),
		.periods    (ring_periods),
		.active     (ring_active_status)
	);

	// ****************************************
	// Register and timing logic
	// ****************************************
	always_comb begin
		r_d = r_q;
		r_d.go       = 1'b0;
		r_d.cad_tick = 1'b0;
		r_d.ind_tick = 1'b0;

		// Cadence step divider.
		if (r_q.cad_div == 16'(CAD_CYCLES - 1)) begin
			r_d.cad_div  = 16'h0000;
			r_d.cad_tick = 1'b1;
		end else begin
			r_d.cad_div = 16'(r_q.cad_div + 16'd1);
		end

		// Indirect update divider.
		if (r_q.ind_div == 16'(IND_CYCLES - 1)) begin
			r_d.ind_div  = 16'h0000;
			r_d.ind_tick = 1'b1;
		end else begin
			r_d.ind_div = 16'(r_q.ind_div + 16'd1);
		end

		// An address write in the update cycle is kept for the next update.
		if (r_q.ind_tick && r_q.indirect_pending
			&& !(reg_wr && reg_addr == `TRC_OFF_IND_ADDR)) begin
			r_d.go               = 1'b1;
			r_d.indirect_pending = 1'b0;
		end

		if (ind_rd_valid) begin
			r_d.indirect_data = ind_rd_data;
		end

		// Line hand-over happens only at the dc feed level, both ways.
		if (ring_dc_match) begin
			r_d.ring_on_line_flag = ring_active_status;
		end

		if (reg_wr) begin
			unique case (reg_addr)
				`TRC_OFF_IND_DLO: begin
					r_d.indirect_data[7:0] = reg_wdata;
					r_d.data_written       = 1'b1;
				end
				`TRC_OFF_IND_DHI: begin
					r_d.indirect_data[15:8] = reg_wdata;
					r_d.data_written        = 1'b1;
				end
				`TRC_OFF_IND_ADDR: begin
					r_d.indirect_address = reg_wdata;
					r_d.indirect_pending = 1'b1;
					r_d.is_write         = r_q.data_written;
					r_d.data_written     = 1'b0;
				end
				`TRC_OFF_TONE1: r_d.t1_ctrl = reg_wdata[6:0];
				`TRC_OFF_TONE2: r_d.t2_ctrl = reg_wdata[5:0];
				`TRC_OFF_RING: begin
					r_d.ring_on_timer_en   = reg_wdata[`TRC_BIT_ON_TMR];
					r_d.ring_off_timer_en  = reg_wdata[`TRC_BIT_OFF_TMR];
					r_d.ring_dc_offset_en  = reg_wdata[`TRC_BIT_DC_OFS];
					r_d.ring_waveshape_sel = reg_wdata[`TRC_BIT_SHAPE];
				end
				`TRC_OFF_RING_RUN: r_d.ring_osc_enable = reg_wdata[0];
				default: r_d.rdata = r_q.rdata;
			endcase
		end

		r_d.rdata = `TRC_RESET_BYTE;
		if (reg_rd) begin
			unique case (reg_addr)
				`TRC_OFF_IND_DLO:  r_d.rdata = r_q.indirect_data[7:0];
				`TRC_OFF_IND_DHI:  r_d.rdata = r_q.indirect_data[15:8];
				`TRC_OFF_IND_ADDR: r_d.rdata = r_q.indirect_address;
				`TRC_OFF_IND_STAT: r_d.rdata = {7'h00, r_q.indirect_pending};
				`TRC_OFF_TONE1:    r_d.rdata = {tone_one_active, r_q.t1_ctrl};
				`TRC_OFF_TONE2:    r_d.rdata = {tone_two_active, 1'b0, r_q.t2_ctrl};
				`TRC_OFF_RING:     r_d.rdata = {ring_active_status, 1'b0,
					r_q.ring_on_line_flag, r_q.ring_on_timer_en,
					r_q.ring_off_timer_en, r_q.ring_osc_enable,
					r_q.ring_dc_offset_en, r_q.ring_waveshape_sel};
				`TRC_OFF_RING_RUN: r_d.rdata = {7'h00, r_q.ring_osc_enable};
				default:           r_d.rdata = `TRC_RESET_BYTE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata = r_q.rdata;

	assign ind_req.go               = r_q.go;
	assign ind_req.is_write         = r_q.is_write;
	assign ind_req.indirect_address = r_q.indirect_address;
	assign ind_req.indirect_data    = r_q.indirect_data;

	assign route.tone_one_tx = tone_one_active && r_q.t1_ctrl[`TRC_BIT_ROUTE_TX];
	assign route.tone_one_rx = tone_one_active && r_q.t1_ctrl[`TRC_BIT_ROUTE_RX];
	assign route.tone_two_tx = tone_two_active && r_q.t2_ctrl[`TRC_BIT_ROUTE_TX];
	assign route.tone_two_rx = tone_two_active && r_q.t2_ctrl[`TRC_BIT_ROUTE_RX];

	// Holding off the line drive keeps the waveform continuous with the dc feed.
	assign ring.ring_active        = ring_active_status;
	assign ring.ring_line_drive    = r_q.ring_on_line_flag;
	assign ring.ring_dc_offset_en  = r_q.ring_dc_offset_en;
	assign ring.ring_waveshape_sel = r_q.ring_waveshape_sel;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_wr(logic [7:0] a);
		reg_wr && reg_addr == a;
	endsequence

	sequence s_rd(logic [7:0] a);
		reg_rd && reg_addr == a;
	endsequence

	a_ind_pend_set: assert property (s_wr(`TRC_OFF_IND_ADDR) |=> r_q.indirect_pending)
		else $error("address write did not set pending");
	a_ind_pend_read: assert property (s_rd(`TRC_OFF_IND_STAT)
		|=> reg_rdata == {7'h00, $past(r_q.indirect_pending)})
		else $error("pending flag read back wrong");
	a_ind_update: assert property (r_q.indirect_pending && r_q.ind_tick
		&& !reg_wr |=> ind_req.go && !r_q.indirect_pending)
		else $error("pending transfer not issued at update");
	a_ind_kind: assert property (s_wr(`TRC_OFF_IND_DLO) ##1 s_wr(`TRC_OFF_IND_ADDR)
		|=> ind_req.is_write)
		else $error("data then address not taken as a write");
	a_tone1_status: assert property (s_rd(`TRC_OFF_TONE1)
		|=> reg_rdata[7] == $past(tone_one_active))
		else $error("tone one status read wrong");
	a_tone1_field: assert property (s_wr(`TRC_OFF_TONE1) ##1 s_rd(`TRC_OFF_TONE1)
		|=> reg_rdata[6:0] == $past(reg_wdata[6:0], 2))
		else $error("tone one control not kept");
	a_tone2_resv: assert property (s_rd(`TRC_OFF_TONE2) |=> reg_rdata[6] == 1'b0)
		else $error("tone two reserved bit nonzero");
	a_ring_resv: assert property (s_rd(`TRC_OFF_RING)
		|=> reg_rdata[6] == 1'b0 && reg_rdata[7] == $past(ring_active_status))
		else $error("ringing status byte wrong");
	a_ring_hold: assert property (!ring.ring_line_drive && !ring_dc_match
		|=> !ring.ring_line_drive)
		else $error("ringing driven before meeting dc feed");
	a_ring_enable: assert property (s_wr(`TRC_OFF_RING_RUN) ##1 s_rd(`TRC_OFF_RING)
		|=> reg_rdata[2] == $past(reg_wdata[0], 2))
		else $error("ringing enable not reflected");
	a_tick_gap: assert property (r_q.cad_tick |=> !r_q.cad_tick)
		else $error("cadence step pulse too long");

	// ****************************************
	// Routing checks
	// ****************************************
	a_t1_route_off: assert property (!tone_one_active |-> !route.tone_one_tx && !route.tone_one_rx)
		else $error("tone one routed while inactive");
	a_t1_route_none: assert property (r_q.t1_ctrl[1:0] == 2'b00
		|-> !route.tone_one_tx && !route.tone_one_rx)
		else $error("tone one routed with no path chosen");
	a_t1_route_both: assert property (tone_one_active && r_q.t1_ctrl[1:0] == 2'b11
		|-> route.tone_one_tx && route.tone_one_rx)
		else $error("tone one not routed to both paths");
	a_t2_route_off: assert property (!tone_two_active |-> !route.tone_two_tx && !route.tone_two_rx)
		else $error("tone two routed while inactive");
	a_t2_route_none: assert property (r_q.t2_ctrl[1:0] == 2'b00
		|-> !route.tone_two_tx && !route.tone_two_rx)
		else $error("tone two routed with no path chosen");
	a_t2_route_both: assert property (tone_two_active && r_q.t2_ctrl[1:0] == 2'b11
		|-> route.tone_two_tx && route.tone_two_rx)
		else $error("tone two not routed to both paths");

	// ****************************************
	// Register and indirect checks
	// ****************************************
	a_stat_zero: assert property (s_rd(`TRC_OFF_IND_STAT) |=> reg_rdata[7:1] == 7'h00)
		else $error("pending status upper bits nonzero");
	a_go_pulse: assert property (ind_req.go |=> !ind_req.go)
		else $error("indirect request longer than one cycle");
	a_ind_read_kind: assert property (s_wr(`TRC_OFF_IND_ADDR) && !r_q.data_written
		|=> !ind_req.is_write)
		else $error("address only write not taken as a read");
	a_ind_load: assert property (ind_rd_valid && !reg_wr
		|=> ind_req.indirect_data == $past(ind_rd_data))
		else $error("indirect read data not loaded");
	a_t1_status_ro: assert property (s_wr(`TRC_OFF_TONE1) ##1 s_rd(`TRC_OFF_TONE1)
		|=> reg_rdata[7] == $past(tone_one_active))
		else $error("tone one status taken from write data");
	a_t2_field: assert property (s_wr(`TRC_OFF_TONE2) ##1 s_rd(`TRC_OFF_TONE2)
		|=> reg_rdata[5:0] == $past(reg_wdata[5:0], 2))
		else $error("tone two control not kept");
	a_ring_offset: assert property (s_wr(`TRC_OFF_RING)
		|=> ring.ring_dc_offset_en == $past(reg_wdata[1]))
		else $error("ringing offset select not taken");
	a_ring_shape: assert property (s_wr(`TRC_OFF_RING)
		|=> ring.ring_waveshape_sel == $past(reg_wdata[0]))
		else $error("ringing waveshape select not taken");
	a_ring_timers: assert property (s_wr(`TRC_OFF_RING)
		|=> {r_q.ring_on_timer_en, r_q.ring_off_timer_en} == $past(reg_wdata[4:3]))
		else $error("ringing timer enables not taken");
	a_ring_ro_en: assert property (s_wr(`TRC_OFF_RING)
		|=> r_q.ring_osc_enable == $past(r_q.ring_osc_enable))
		else $error("read-only ringing enable changed by write");
	a_ring_drive_on: assert property (ring_dc_match
		|=> ring.ring_line_drive == $past(ring_active_status))
		else $error("line hand-over missed at dc match");

endmodule : trc_ctrl

/* File: trc_testbench.sv */
// Self-checking testbench for the tone and ringing control register bank.
`timescale 1ns/1ps
`include "trc_map.svh"
`define TRC_CHECK(got, exp) begin \
	checks_done++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
	end \
end
module testbench
	import trc_pkg::*;
;
	logic            clk;
	logic            nrst;
	logic [7:0]      reg_addr;
	logic [7:0]      reg_wdata;
	logic            reg_wr;
	logic            reg_rd;
	logic [7:0]      reg_rdata;
	trc_period_type  tone_one_periods;
	trc_period_type  tone_two_periods;
	trc_period_type  ring_periods;
	logic            tone_one_zero_cross;
	logic            tone_two_zero_cross;
	logic            ring_dc_match;
	logic            ind_rd_valid;
	logic [15:0]     ind_rd_data;
	trc_ind_req_type ind_req;
	trc_route_type   route;
	trc_ring_type    ring;
	int              mismatches;
	int              checks_done;
	int              rises;
	int              act_cycles;
	logic [1:0]      mon_sel;
	logic            mon_sig;
	logic            mon_prev;
	logic [7:0]      osc_addr;
	logic [3:0]      exp_route;

	// Short cadence and update counts keep every period 9 to 24 cycles long.
	trc_ctrl #(.CAD_CYCLES(8), .IND_CYCLES(20)) i_trc_ctrl (
		.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tone_one_periods(tone_one_periods), .tone_two_periods(tone_two_periods),
		.ring_periods(ring_periods), .tone_one_zero_cross(tone_one_zero_cross),
		.tone_two_zero_cross(tone_two_zero_cross), .ring_dc_match(ring_dc_match),
		.ind_rd_valid(ind_rd_valid), .ind_rd_data(ind_rd_data), .ind_req(ind_req),
		.route(route), .ring(ring));

	always #2 clk = ~clk;

	// ****************************************
	// Activity monitor
	// ****************************************
	always_comb begin
		case (mon_sel)
			2'h0: mon_sig = route.tone_one_tx;
			2'h1: mon_sig = route.tone_two_tx;
			default: mon_sig = ring.ring_active;
		endcase
	end

	always @(posedge clk) begin
		if (mon_sig === 1'b1 && mon_prev !== 1'b1) begin
			rises++;
		end
		if (mon_sig === 1'b1) begin
			act_cycles++;
		end
		mon_prev <= mon_sig;
	end

	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= addr;
		reg_wdata <= data;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_expect(input logic [7:0] addr, input logic [7:0] exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= addr;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		`TRC_CHECK(reg_rdata, exp)
	endtask : reg_expect

	task automatic pulse(input int which);
		@(posedge clk);
		case (which)
			0: tone_one_zero_cross <= 1'b1;
			1: tone_two_zero_cross <= 1'b1;
			2: ring_dc_match <= 1'b1;
			default: ind_rd_valid <= 1'b1;
		endcase
		@(posedge clk);
		tone_one_zero_cross <= 1'b0;
		tone_two_zero_cross <= 1'b0;
		ring_dc_match       <= 1'b0;
		ind_rd_valid        <= 1'b0;
	endtask : pulse

	task automatic wait_go();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (ind_req.go !== 1'b1 && n < 60);
		`TRC_CHECK(ind_req.go, 1'b1)
	endtask : wait_go

	// Counts rising edges and active cycles over a fixed window, then switches off.
	task automatic run_cadence(input logic [1:0] sel, input logic [7:0] addr,
			input logic [7:0] ctrl, input int r_min, input int r_max,
			input int a_min, input int a_max);
		mon_sel = sel;
		reg_write(addr, ctrl);
		#1;
		rises      = 0;
		act_cycles = 0;
		repeat (400) @(posedge clk);
		`TRC_CHECK(rises >= r_min && rises <= r_max, 1'b1)
		`TRC_CHECK(act_cycles >= a_min && act_cycles <= a_max, 1'b1)
		reg_write(addr, 8'h00);
		repeat (4) @(posedge clk);
	endtask : run_cadence

	task automatic print_verdict();
		if (mismatches == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{tone_one_zero_cross, tone_two_zero_cross, ring_dc_match, ind_rd_valid} = '0;
		ind_rd_data = 16'hbeef;
		tone_one_periods = '{on_cnt: 16'h0003, off_cnt: 16'h0002};
		tone_two_periods = '{on_cnt: 16'h0003, off_cnt: 16'h0002};
		ring_periods = '{on_cnt: 16'h0002, off_cnt: 16'h0002};
		{mismatches, checks_done, rises, act_cycles} = '0;
		mon_sel = 2'h0;
		mon_prev = 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		for (int a = 8'h1f; a <= 8'h22; a++) begin
			reg_expect(8'(a), 8'h00);
		end
		reg_write(`TRC_OFF_IND_STAT, 8'hff);
		reg_expect(`TRC_OFF_IND_STAT, 8'h00);
		reg_write(`TRC_OFF_TONE1, 8'hc0);
		reg_expect(`TRC_OFF_TONE1, 8'h40);
		reg_write(`TRC_OFF_TONE2, 8'hc0);
		reg_expect(`TRC_OFF_TONE2, 8'h00);
		reg_write(8'h23, 8'hff);
		reg_expect(8'h23, 8'h00);
		reg_write(`TRC_OFF_TONE1, 8'h00);
		// Every routing code on both tones, each code first with the tone on and then with it off.
		for (int i = 0; i < 2; i++) begin
			osc_addr = 8'(`TRC_OFF_TONE1 + i);
			for (int c = 0; c < 4; c++) begin
				reg_write(osc_addr, 8'(8'h04 | c));
				repeat (3) @(posedge clk);
				exp_route = (i == 0) ? {c[0], c[1], 2'b00} : {2'b00, c[0], c[1]};
				`TRC_CHECK(route, exp_route)
				reg_expect(osc_addr, 8'(8'h84 | c));
				reg_write(osc_addr, 8'(c));
				repeat (3) @(posedge clk);
				`TRC_CHECK(route, 4'h0)
				reg_expect(osc_addr, 8'(c));
			end
			reg_write(osc_addr, 8'h35);
			repeat (100) @(posedge clk);
			reg_expect(osc_addr, 8'hb5);
			pulse(i);
			repeat (3) @(posedge clk);
			reg_expect(osc_addr, 8'h35);
			reg_write(osc_addr, 8'h00);
		end
		run_cadence(2'h0, `TRC_OFF_TONE1, 8'h1d, 1, 1, 15, 26);
		run_cadence(2'h0, `TRC_OFF_TONE1, 8'h5d, 5, 12, 150, 300);
		run_cadence(2'h0, `TRC_OFF_TONE1, 8'h0d, 1, 1, 390, 400);
		run_cadence(2'h0, `TRC_OFF_TONE1, 8'h55, 1, 1, 15, 26);
		run_cadence(2'h1, `TRC_OFF_TONE2, 8'h1d, 5, 12, 150, 300);
		run_cadence(2'h1, `TRC_OFF_TONE2, 8'h15, 1, 1, 15, 26);
		run_cadence(2'h1, `TRC_OFF_TONE2, 8'h0d, 1, 1, 390, 400);
		// Ringing: read-only enable, line hand-over only at a dc match.
		reg_write(`TRC_OFF_RING, 8'hff);
		reg_expect(`TRC_OFF_RING, 8'h1b);
		`TRC_CHECK(ring, 4'b0011)
		reg_write(`TRC_OFF_RING, 8'h03);
		reg_write(`TRC_OFF_RING_RUN, 8'h01);
		repeat (3) @(posedge clk);
		reg_expect(`TRC_OFF_RING, 8'h87);
		`TRC_CHECK(ring, 4'b1011)
		pulse(2);
		repeat (2) @(posedge clk);
		reg_expect(`TRC_OFF_RING, 8'ha7);
		`TRC_CHECK(ring, 4'b1111)
		reg_write(`TRC_OFF_RING, 8'h00);
		reg_expect(`TRC_OFF_RING, 8'ha4);
		`TRC_CHECK(ring, 4'b1100)
		reg_write(`TRC_OFF_RING_RUN, 8'h00);
		repeat (3) @(posedge clk);
		`TRC_CHECK(ring, 4'b0100)
		reg_expect(`TRC_OFF_RING, 8'h20);
		pulse(2);
		repeat (2) @(posedge clk);
		`TRC_CHECK(ring, 4'b0000)
		reg_write(`TRC_OFF_RING, 8'h18);
		run_cadence(2'h2, `TRC_OFF_RING_RUN, 8'h01, 5, 16, 120, 280);
		reg_write(`TRC_OFF_RING, 8'h10);
		run_cadence(2'h2, `TRC_OFF_RING_RUN, 8'h01, 1, 1, 7, 18);
		reg_write(`TRC_OFF_RING, 8'h08);
		run_cadence(2'h2, `TRC_OFF_RING_RUN, 8'h01, 1, 1, 390, 400);
		// Indirect: an address-only read first, so the write follows right after an update.
		reg_write(`TRC_OFF_IND_ADDR, 8'h57);
		wait_go();
		`TRC_CHECK({ind_req.is_write, ind_req.indirect_address}, 9'h057)
		reg_write(`TRC_OFF_IND_DLO, 8'h34);
		reg_write(`TRC_OFF_IND_DHI, 8'h12);
		reg_write(`TRC_OFF_IND_ADDR, 8'h56);
		reg_expect(`TRC_OFF_IND_STAT, 8'h01);
		wait_go();
		`TRC_CHECK(ind_req[24:0], 25'h1561234)
		reg_expect(`TRC_OFF_IND_STAT, 8'h00);
		pulse(3);
		reg_expect(`TRC_OFF_IND_DLO, 8'hef);
		reg_expect(`TRC_OFF_IND_DHI, 8'hbe);
		print_verdict();
	end

	initial begin
		#100000;
		mismatches++;
		print_verdict();
	end

endmodule : testbench
